// ==== core/cbc_bond_ctrl.sv ====
// Multi-device channel bonding controller with APB registers
// Behaviour
// - Bonding status carries bonding events, timed like receive output data
// - Primary select low makes master driving status; high makes status an input
// - Master broadcasts the elastic buffer status of one receive channel
// - Broadcast channel chosen by the two lead channel select inputs
// - Code 00 means word sync received, code 11 means normal data
// - Code 01 inserts one K28.5 after the next framing character
// - Code 10 deletes the next framing character
// - Status driven only as master, quad bonded, receive on reference clock
// - Primary select ignored unless quad bonded and receive on reference clock
// - All-bonded is wired AND, high only when every channel is framed
// - All-bonded driven only when quad bonded on reference clock
// - Inhibit low blocks offset adjustment until all bonded channels saw sequence
// - Inhibit high lets each channel with the sequence align alone, once the lead channel saw it too
// - Channels bond only in a group holding the lead channel
// - Status lines reach only slave devices, which take master status
// - Device reset holds state and pointers; outputs settle within 16 cycles
`timescale 1ns/1ps
module cbc_bond_ctrl (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration pins
  input wire logic primary_sel_n,
  input wire logic alignment_inhibit_n,
  input wire logic lead_channel_sel_lo,
  input wire logic lead_channel_sel_hi,
  input wire logic test_and_device_reset_n,
  // Bonding status bus, open drain
  input wire logic [1:0] bond_status_bus_in,
  output logic [1:0] bond_status_bus_out,
  output logic [1:0] bond_status_bus_oe,
  // All-bonded indicator, open drain
  input wire logic bond_all_in,
  output logic bond_all_out,
  output logic bond_all_oe,
  // Receive channels
  input wire logic [7:0] chan_eb_status,
  input wire logic [3:0] chan_framed,
  input wire logic [3:0] chan_bond_seen,
  output logic [3:0] chan_offset_adjust_en,
  output logic [1:0] chan_eb_cmd,
  output logic chan_eb_ptr_init,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    cbc_pkg::cbc_state_t state;
    logic [4:0] settle_cnt;
    logic [1:0] ctrl;
    logic [3:0] int_stat;
    logic [3:0] int_en;
    logic [1:0] bus_oe;
    logic all_oe;
    logic [3:0] adjust_en;
    logic [1:0] eb_cmd;
    logic eb_ptr_init;
    logic all_bonded;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cbc_state_vec_t;

  cbc_state_vec_t st_reg;
  cbc_state_vec_t st_next;

  cbc_pin_if pins ();

  // ==========================================================
  // Pin synchronisers
  assign pins.raw = {bond_all_in, bond_status_bus_in, lead_channel_sel_hi,
                     lead_channel_sel_lo, alignment_inhibit_n, primary_sel_n};
  assign pins.dev_rst_raw_n = test_and_device_reset_n;

  cbc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins)
  );

  function automatic logic [1:0] pick_code(input logic [7:0] codes, input logic [1:0] idx);
    pick_code = codes[{idx, 1'b0} +: 2];
  endfunction

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  // ==========================================================
  // Decoded configuration
  logic [1:0] lead;
  logic cfg_ok;
  logic is_master;
  logic is_slave;
  logic [1:0] master_code;
  logic [1:0] bus_in;
  logic [3:0] group;
  logic group_seen;
  logic all_framed;
  logic run;

  assign lead = {pins.synced[cbc_pkg::PIN_SEL_HI], pins.synced[cbc_pkg::PIN_SEL_LO]};
  assign cfg_ok = st_reg.ctrl[cbc_pkg::CTRL_QUAD_BIT] & st_reg.ctrl[cbc_pkg::CTRL_REF_CLOCK_BIT];
  assign is_master = cfg_ok & ~pins.synced[cbc_pkg::PIN_MASTER_N];
  assign is_slave = cfg_ok & pins.synced[cbc_pkg::PIN_MASTER_N];
  assign master_code = pick_code(chan_eb_status, lead);
  assign bus_in = pins.synced[cbc_pkg::PIN_BUS_LSB +: 2];
  assign group = st_reg.ctrl[cbc_pkg::CTRL_QUAD_BIT] ? 4'hf : (4'h1 << lead);
  assign group_seen = &(chan_bond_seen | ~group);
  assign all_framed = &chan_framed;
  assign run = (st_reg.state == cbc_pkg::ST_RUN);

  // ==========================================================
  // Next state
  logic [1:0] cmd;
  logic bonded_now;
  logic setup;
  logic access;
  logic mapped;

  always_comb begin
    st_next = st_reg;
    cmd = cbc_pkg::CODE_NORMAL;
    bonded_now = 1'b0;
    setup = psel & ~penable;
    access = psel & penable & st_reg.pready;
    mapped = is_addr(paddr, cbc_pkg::ADDR_CTRL) || is_addr(paddr, cbc_pkg::ADDR_STATUS) ||
             is_addr(paddr, cbc_pkg::ADDR_INT_STAT) || is_addr(paddr, cbc_pkg::ADDR_INT_CLR) ||
             is_addr(paddr, cbc_pkg::ADDR_INT_EN);

    case (st_reg.state)
      cbc_pkg::ST_HOLD: begin
        st_next.settle_cnt = 5'h00;
        if (pins.dev_rst_n) begin
          st_next.state = cbc_pkg::ST_SETTLE;
        end
      end
      cbc_pkg::ST_SETTLE: begin
        if (st_reg.settle_cnt == cbc_pkg::SETTLE_CYCLES - 5'h01) begin
          st_next.state = cbc_pkg::ST_RUN;
        end else begin
          st_next.settle_cnt = st_reg.settle_cnt + 5'h01;
        end
      end
      cbc_pkg::ST_RUN: begin
        st_next.settle_cnt = 5'h00;
      end
      default: begin
        st_next.state = cbc_pkg::ST_HOLD;
      end
    endcase
    if (!pins.dev_rst_n) begin
      st_next.state = cbc_pkg::ST_HOLD;
    end
    st_next.eb_ptr_init = !pins.dev_rst_n || (st_reg.state == cbc_pkg::ST_HOLD);

    if (run) begin
      // slave follows the bus, master its lead channel
      if (is_master) begin
        cmd = master_code;
      end else if (is_slave) begin
        cmd = bus_in;
      end
      // global level is the wired AND when bonded
      bonded_now = cfg_ok ? (pins.synced[cbc_pkg::PIN_ALL] & all_framed) : all_framed;
    end

    st_next.eb_cmd = cmd;
    // drive only as master; open drain pulls zeros low
    st_next.bus_oe = (run && is_master) ? ~master_code : 2'h0;
    // drive only when bonded on reference clock
    st_next.all_oe = run & cfg_ok & ~all_framed;
    st_next.all_bonded = bonded_now;

    // inhibit low holds every channel back until the whole group saw the sequence
    if (!run) begin
      st_next.adjust_en = 4'h0;
    end else if (!pins.synced[cbc_pkg::PIN_INHIBIT_N]) begin
      st_next.adjust_en = group_seen ? group : 4'h0;
    end else begin
      st_next.adjust_en = chan_bond_seen & group & {4{chan_bond_seen[lead]}};
    end

    // APB slave: one wait-free access phase
    st_next.pready = setup;
    if (setup) begin
      st_next.pslverr = ~mapped;
      st_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (is_addr(paddr, cbc_pkg::ADDR_CTRL)) begin
          st_next.prdata[1:0] = st_reg.ctrl;
        end else if (is_addr(paddr, cbc_pkg::ADDR_STATUS)) begin
          st_next.prdata[cbc_pkg::STAT_FRAMED_LSB +: 4] = chan_framed;
          st_next.prdata[cbc_pkg::STAT_SEEN_LSB +: 4] = chan_bond_seen;
          st_next.prdata[cbc_pkg::STAT_MASTER_BIT] = is_master;
          st_next.prdata[cbc_pkg::STAT_SLAVE_BIT] = is_slave;
          st_next.prdata[cbc_pkg::STAT_ALL_BIT] = st_reg.all_bonded;
          st_next.prdata[cbc_pkg::STAT_CMD_LSB +: 2] = st_reg.eb_cmd;
          st_next.prdata[cbc_pkg::STAT_RUN_BIT] = run;
        end else if (is_addr(paddr, cbc_pkg::ADDR_INT_STAT)) begin
          st_next.prdata[3:0] = st_reg.int_stat;
        end else if (is_addr(paddr, cbc_pkg::ADDR_INT_EN)) begin
          st_next.prdata[3:0] = st_reg.int_en;
        end
      end
    end else if (access) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end

    if (access && pwrite) begin
      if (is_addr(paddr, cbc_pkg::ADDR_CTRL)) begin
        st_next.ctrl = pwdata[1:0];
      end
      if (is_addr(paddr, cbc_pkg::ADDR_INT_EN)) begin
        st_next.int_en = pwdata[3:0];
      end
      if (is_addr(paddr, cbc_pkg::ADDR_INT_CLR)) begin
        st_next.int_stat = st_reg.int_stat & ~pwdata[3:0];
      end
    end

    // Events set after the clear so a same-cycle event survives
    if (run && (is_master || is_slave)) begin
      if (cmd == cbc_pkg::CODE_WSYNC) begin
        st_next.int_stat[cbc_pkg::INT_WSYNC] = 1'b1;
      end
      if (cmd == cbc_pkg::CODE_INSERT) begin
        st_next.int_stat[cbc_pkg::INT_INSERT] = 1'b1;
      end
      if (cmd == cbc_pkg::CODE_DELETE) begin
        st_next.int_stat[cbc_pkg::INT_DELETE] = 1'b1;
      end
    end
    if (bonded_now && !st_reg.all_bonded) begin
      st_next.int_stat[cbc_pkg::INT_BONDED] = 1'b1;
    end
    st_next.irq = |(st_next.int_stat & st_next.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{state: cbc_pkg::ST_HOLD, settle_cnt: 5'h00, ctrl: cbc_pkg::CTRL_RESET,
                  int_stat: 4'h0, int_en: cbc_pkg::INT_EN_RESET, bus_oe: 2'h0,
                  all_oe: 1'b0, adjust_en: 4'h0, eb_cmd: cbc_pkg::CODE_NORMAL,
                  eb_ptr_init: 1'b1, all_bonded: 1'b0, irq: 1'b0,
                  prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign bond_status_bus_out = 2'h0;
  assign bond_status_bus_oe = st_reg.bus_oe;
  assign bond_all_out = 1'b0;
  assign bond_all_oe = st_reg.all_oe;
  assign chan_offset_adjust_en = st_reg.adjust_en;
  assign chan_eb_cmd = st_reg.eb_cmd;
  assign chan_eb_ptr_init = st_reg.eb_ptr_init;
  assign irq = st_reg.irq;

  // ==========================================================
  // Assertions
  a_status_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (bond_status_bus_oe != 2'h0) |-> $past(is_master && run))
    else $error("status bus driven while not an active master");

  a_status_lead_code: assert property (@(posedge pclk) disable iff (!presetn)
    $past(is_master && run) |-> (bond_status_bus_oe == ~$past(master_code)))
    else $error("status bus does not carry lead channel code");

  a_bondall_gate: assert property (@(posedge pclk) disable iff (!presetn)
    bond_all_oe |-> $past(cfg_ok))
    else $error("all-bonded driven without quad bonding");

  a_bondall_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(cfg_ok && run) |-> (bond_all_oe == !$past(all_framed)))
    else $error("all-bonded pull does not follow framing");

  a_inhibit_block: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!pins.synced[cbc_pkg::PIN_INHIBIT_N] && !group_seen) |->
      (chan_offset_adjust_en == 4'h0))
    else $error("offset adjusted before all bonded channels saw sequence");

  a_lead_member: assert property (@(posedge pclk) disable iff (!presetn)
    (chan_offset_adjust_en != 4'h0) |-> $past(chan_bond_seen[lead]))
    else $error("adjustment without lead channel in group");

  a_slave_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $past(is_slave && run) |-> (chan_eb_cmd == $past(bus_in)))
    else $error("slave command not taken from status bus");

  a_reset_settle: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st_reg.state == cbc_pkg::ST_HOLD) |->
      ##16 (st_reg.state == cbc_pkg::ST_RUN || st_reg.state == cbc_pkg::ST_HOLD))
    else $error("settle window not sixteen cycles");

  a_wsync_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    $past(run && is_master && master_code == cbc_pkg::CODE_WSYNC) |->
      st_reg.int_stat[cbc_pkg::INT_WSYNC])
    else $error("word sync event lost");

  a_cmd_with_bus: assert property (@(posedge pclk) disable iff (!presetn)
    $past(is_master && run) |-> (bond_status_bus_oe == ~chan_eb_cmd))
    else $error("status bus and local command out of step");

  a_slave_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    $past(is_slave) |-> (bond_status_bus_oe == 2'h0))
    else $error("status bus driven while listening");

  a_inhibit_free: assert property (@(posedge pclk) disable iff (!presetn)
    $past(run && pins.synced[cbc_pkg::PIN_INHIBIT_N]) |->
      ((chan_offset_adjust_en & ~$past(chan_bond_seen)) == 4'h0))
    else $error("channel adjusted without bonding sequence");

  a_ptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!pins.dev_rst_n) |-> chan_eb_ptr_init)
    else $error("pointers released during device reset");

endmodule

// ==== core/cbc_pin_if.sv ====
// Carrier between the controller and its pin synchroniser
`timescale 1ns/1ps
interface cbc_pin_if;
  logic [cbc_pkg::PIN_W-1:0] raw;
  logic [cbc_pkg::PIN_W-1:0] synced;
  logic dev_rst_raw_n;
  logic dev_rst_n;
  modport sync_side (input raw, input dev_rst_raw_n, output synced, output dev_rst_n);
  modport core_side (output raw, output dev_rst_raw_n, input synced, input dev_rst_n);
endinterface

// ==== core/cbc_pin_sync.sv ====
// Two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
module cbc_pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  cbc_pin_if.sync_side pins
);

  typedef struct packed {
    logic [cbc_pkg::PIN_W:0] first;
    logic [cbc_pkg::PIN_W:0] second;
  } cbc_sync_state_t;

  cbc_sync_state_t s_reg;
  cbc_sync_state_t s_next;

  // ==========================================================
  // Stage one feeds stage two only
  always_comb begin
    s_next = s_reg;
    s_next.first = {pins.dev_rst_raw_n, pins.raw};
    s_next.second = s_reg.first;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.synced = s_reg.second[cbc_pkg::PIN_W-1:0];
  assign pins.dev_rst_n = s_reg.second[cbc_pkg::PIN_W];

endmodule

// ==== core/cbc_pkg.sv ====
// Shared constants and types for the channel bonding controller
package cbc_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_STAT = 12'h008;
  localparam logic [11:0] ADDR_INT_CLR = 12'h00c;
  localparam logic [11:0] ADDR_INT_EN = 12'h010;

  // ==========================================================
  // Control fields
  localparam int CTRL_QUAD_BIT = 0;
  localparam int CTRL_REF_CLOCK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] INT_EN_RESET = 4'h0;

  // ==========================================================
  // Status fields
  localparam int STAT_FRAMED_LSB = 0;
  localparam int STAT_SEEN_LSB = 4;
  localparam int STAT_MASTER_BIT = 8;
  localparam int STAT_SLAVE_BIT = 9;
  localparam int STAT_ALL_BIT = 10;
  localparam int STAT_CMD_LSB = 12;
  localparam int STAT_RUN_BIT = 14;

  // ==========================================================
  // Interrupt bits
  localparam int INT_WSYNC = 0;
  localparam int INT_INSERT = 1;
  localparam int INT_DELETE = 2;
  localparam int INT_BONDED = 3;

  // ==========================================================
  // Bonding status codes
  localparam logic [1:0] CODE_WSYNC = 2'h0;
  localparam logic [1:0] CODE_INSERT = 2'h1;
  localparam logic [1:0] CODE_DELETE = 2'h2;
  localparam logic [1:0] CODE_NORMAL = 2'h3;

  // ==========================================================
  // Timing, in pclk cycles
  localparam logic [4:0] SETTLE_CYCLES = 5'h10;

  // ==========================================================
  // Positions of the pin inputs in the synchroniser bank
  localparam int PIN_W = 7;
  localparam int PIN_MASTER_N = 0;
  localparam int PIN_INHIBIT_N = 1;
  localparam int PIN_SEL_LO = 2;
  localparam int PIN_SEL_HI = 3;
  localparam int PIN_BUS_LSB = 4;
  localparam int PIN_ALL = 6;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b11
  } cbc_state_t;

endpackage

// ==== verification/cbc_bond_ctrl_tb.sv ====
// Self-checking bench for the channel bonding controller
`timescale 1ns/1ps
module cbc_bond_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic primary_sel_n, alignment_inhibit_n, lead_channel_sel_lo, lead_channel_sel_hi;
  logic test_and_device_reset_n, bond_all_out, bond_all_oe, chan_eb_ptr_init, irq;
  logic [1:0] bond_status_bus_out, bond_status_bus_oe, chan_eb_cmd, bus_lvl, far_code;
  logic [7:0] chan_eb_status;
  logic [3:0] chan_framed, chan_bond_seen, chan_offset_adjust_en;
  logic far_en, far_nf, all_lvl, err;
  int bad_count = 0;
  int checks_done = 0;

  cbc_bond_ctrl cbc_bond_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primary_sel_n(primary_sel_n),
    .alignment_inhibit_n(alignment_inhibit_n), .lead_channel_sel_lo(lead_channel_sel_lo),
    .lead_channel_sel_hi(lead_channel_sel_hi),
    .test_and_device_reset_n(test_and_device_reset_n), .bond_status_bus_in(bus_lvl),
    .bond_status_bus_out(bond_status_bus_out), .bond_status_bus_oe(bond_status_bus_oe),
    .bond_all_in(all_lvl), .bond_all_out(bond_all_out), .bond_all_oe(bond_all_oe),
    .chan_eb_status(chan_eb_status), .chan_framed(chan_framed),
    .chan_bond_seen(chan_bond_seen), .chan_offset_adjust_en(chan_offset_adjust_en),
    .chan_eb_cmd(chan_eb_cmd), .chan_eb_ptr_init(chan_eb_ptr_init), .irq(irq));

  cbc_far_end cbc_far_end_i (.pclk(pclk), .dut_bus_oe(bond_status_bus_oe),
    .dut_all_oe(bond_all_oe), .drive_code(far_code), .drive_en(far_en),
    .not_framed(far_nf), .bus_level(bus_lvl), .all_level(all_lvl));

  // ==========================================================
  // Shared tasks
  task stop_test;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Slave answer time comes from pready; bounded wait only
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        bad_count++;
        stop_test();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never rewrites psel in this step
    @(posedge pclk);
  endtask

  task set_lead(input int l);
    lead_channel_sel_lo <= l[0];
    lead_channel_sel_hi <= l[1];
    cyc(4);
  endtask

  task wait_run;
    int n;
    n = 0;
    do begin
      apb(1'b0, cbc_pkg::ADDR_STATUS, 32'h0);
      n++;
      if (n > 20) begin
        bad_count++;
        stop_test();
      end
    end while (rd[cbc_pkg::STAT_RUN_BIT] !== 1'b1);
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    apb(1'b0, cbc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, 12'h020, 32'hffffffff);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, cbc_pkg::ADDR_INT_CLR, 32'h0);
    chk(rd, 32'h0, "clear reads zero");
    apb(1'b1, cbc_pkg::ADDR_CTRL, 32'h3);
    apb(1'b0, cbc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h3, "ctrl write");
  endtask

  task t_master;
    logic [7:0] st;
    apb(1'b1, cbc_pkg::ADDR_INT_EN, 32'h2);
    primary_sel_n <= 1'b0;
    for (int l = 0; l < 4; l++) begin
      set_lead(l);
      for (int c = 0; c < 4; c++) begin
        st = 8'hff;
        st[2*l +: 2] = c[1:0];
        chan_eb_status <= st;
        cyc(3);
        chk({30'h0, bond_status_bus_oe}, {30'h0, ~c[1:0]}, "bus pull");
        chk({30'h0, chan_eb_cmd}, c, "local cmd");
        chk({30'h0, bus_lvl}, c, "wire code");
        chk({30'h0, bond_status_bus_out}, 32'h0, "open drain low");
      end
    end
    chk({31'h0, irq}, 32'h1, "irq insert");
    apb(1'b0, cbc_pkg::ADDR_INT_STAT, 32'h0);
    chk(rd & 32'h7, 32'h7, "sticky events");
    apb(1'b1, cbc_pkg::ADDR_INT_CLR, 32'hf);
    cyc(1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, cbc_pkg::ADDR_INT_EN, 32'h0);
    chan_eb_status <= 8'h7f;
    cyc(3);
    chan_eb_status <= 8'hff;
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b0, cbc_pkg::ADDR_INT_STAT, 32'h0);
    chk(rd & 32'h2, 32'h2, "masked still sticky");
  endtask

  task t_all;
    far_nf <= 1'b0;
    chan_framed <= 4'hf;
    cyc(5);
    chk({31'h0, bond_all_oe}, 32'h0, "all framed");
    chk({31'h0, all_lvl}, 32'h1, "wired high");
    chk({31'h0, bond_all_out}, 32'h0, "open drain low");
    apb(1'b0, cbc_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[cbc_pkg::STAT_ALL_BIT]}, 32'h1, "all bonded status");
    chan_framed <= 4'h7;
    cyc(3);
    chk({31'h0, bond_all_oe}, 32'h1, "one unframed");
    chk({31'h0, all_lvl}, 32'h0, "wired level");
    chan_framed <= 4'hf;
  endtask

  task t_adjust;
    set_lead(0);
    chan_bond_seen <= 4'h7;
    cyc(3);
    chk({28'h0, chan_offset_adjust_en}, 32'h0, "inhibit blocks");
    chan_bond_seen <= 4'hf;
    cyc(3);
    chk({28'h0, chan_offset_adjust_en}, 32'hf, "all seen");
    alignment_inhibit_n <= 1'b1;
    chan_bond_seen <= 4'h5;
    cyc(4);
    chk({28'h0, chan_offset_adjust_en}, 32'h5, "independent");
    chan_bond_seen <= 4'ha;
    cyc(3);
    chk({28'h0, chan_offset_adjust_en}, 32'h0, "lead absent");
  endtask

  task t_slave;
    primary_sel_n <= 1'b1;
    far_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      far_code <= c[1:0];
      cyc(6);
      chk({30'h0, chan_eb_cmd}, c, "slave cmd");
      chk({30'h0, bond_status_bus_oe}, 32'h0, "slave silent");
    end
    far_en <= 1'b0;
  endtask

  task t_uncfg;
    primary_sel_n <= 1'b0;
    apb(1'b1, cbc_pkg::ADDR_CTRL, 32'h1);
    chan_eb_status <= 8'h00;
    chan_framed <= 4'h0;
    cyc(4);
    chk({30'h0, bond_status_bus_oe}, 32'h0, "no drive");
    chk({30'h0, chan_eb_cmd}, 32'h3, "select ignored");
    chk({31'h0, bond_all_oe}, 32'h0, "all not driven");
  endtask

  task t_devrst;
    apb(1'b1, cbc_pkg::ADDR_CTRL, 32'h3);
    test_and_device_reset_n <= 1'b0;
    cyc(5);
    chk({31'h0, chan_eb_ptr_init}, 32'h1, "pointers nominal");
    chk({30'h0, bond_status_bus_oe}, 32'h0, "held quiet");
    test_and_device_reset_n <= 1'b1;
    wait_run();
    chk({31'h0, chan_eb_ptr_init}, 32'h0, "pointers free");
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #200us;
    bad_count++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    primary_sel_n = 1'b1;
    alignment_inhibit_n = 1'b0;
    lead_channel_sel_lo = 1'b0;
    lead_channel_sel_hi = 1'b0;
    test_and_device_reset_n = 1'b0;
    chan_eb_status = 8'hff;
    chan_framed = 4'hf;
    chan_bond_seen = 4'h0;
    far_code = 2'h3;
    far_en = 1'b0;
    far_nf = 1'b1;
    cyc(16);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, chan_eb_cmd}, 32'h3, "reset cmd");
    t_regs();
    test_and_device_reset_n <= 1'b1;
    wait_run();
    t_master();
    t_all();
    t_adjust();
    t_slave();
    t_uncfg();
    t_devrst();
    stop_test();
  end
endmodule

// ==== verification/cbc_far_end.sv ====
// Far-end device model, a remote master when drive_en is set, on the open-drain bonding lines
`timescale 1ns/1ps
module cbc_far_end (
  // Clock
  input wire logic pclk,
  // Pulls from the device under test
  input wire logic [1:0] dut_bus_oe,
  input wire logic dut_all_oe,
  // Scenario control
  input wire logic [1:0] drive_code,
  input wire logic drive_en,
  input wire logic not_framed,
  // Resolved wire levels
  output logic [1:0] bus_level,
  output logic all_level
);
  logic [1:0] pull_bus = 2'h0;
  logic pull_all = 1'b0;

  // ==========================================================
  // Pulls change only after an edge, like a real part's pins
  always @(posedge pclk) begin
    // code as a remote master sends it
    pull_bus <= drive_en ? ~drive_code : 2'h0;
    // local framing pulls the wired-AND low
    pull_all <= not_framed;
  end

  // pull-ups hold a released line high
  assign bus_level = ~(dut_bus_oe | pull_bus);
  assign all_level = ~(dut_all_oe | pull_all);
endmodule
